/* spf_pkg.sv */
// Package of constants and types for the self-programming flash controller
//
// Overview of operation
// - Programming starts only when the store instruction executes from the boot section.
// - Boot-section store may address any page, boot pages included.
// - Boot size fuses set the boundary between application and boot regions.
// - First lock set protects the application region independently.
// - Second lock set protects the boot region.
// - The two lock sets are held in one register and programmed together by one mask.
// - A fixed boundary splits flash into fetch-while and halt-on regions.
// - Programming the fetch-while region keeps halt-on region reads served.
// - Programming the halt-on region stalls the core for the whole operation.
// - Fetch-while region returns no valid code during any programming.
// - The boot region lies wholly inside the halt-on region for every size.
// - Busy flag reads one while the fetch-while region is blocked.
// - Region stays blocked after programming until software clears the busy flag.
// - Erase and write act on whole pages; fetch is unaffected by pages.
// - Lock bits program by software or external; only chip erase or reset clears them.
// - Reset vector is 0x0000 unless the select fuse is programmed: boot start.
package spf_pkg;
    localparam int          ADDR_W       = 17;
    localparam int          PAGE_W       = 7;
    localparam logic [31:0] OFS_CTRL     = 32'h0000_0000;
    localparam logic [31:0] OFS_STATUS   = 32'h0000_0004;
    localparam logic [31:0] OFS_LOCKS    = 32'h0000_0008;
    localparam logic [31:0] OFS_CMD      = 32'h0000_000C;
    localparam int          CMD_ERASE    = 0;
    localparam int          CMD_WRITE    = 1;
    localparam int          CMD_RWWCLR   = 2;
    localparam int          CMD_LOCKPROG = 3;
    localparam int          ST_BUSY      = 0;
    localparam int          ST_ACTIVE    = 1;
    localparam int          ST_REFUSED   = 2;
    localparam int          LK_APP_POS   = 0;
    localparam int          LK_BOOT_POS  = 2;
    localparam logic [3:0]  LOCK_RESET   = 4'hF;
    localparam logic [ADDR_W-1:0] RESET_APP_VEC = '0;
    localparam logic [ADDR_W-1:0] HALT_REGION_START = 17'h1C000;
    localparam logic [ADDR_W-1:0] BOOT_START_0 = 17'h1F000;
    localparam logic [ADDR_W-1:0] BOOT_START_1 = 17'h1F800;
    localparam logic [ADDR_W-1:0] BOOT_START_2 = 17'h1FC00;
    localparam logic [ADDR_W-1:0] BOOT_START_3 = 17'h1FE00;
    localparam logic [15:0] PROG_CYCLES  = 16'h0400;
    localparam logic [31:0] BAD_ADDR_DATA = 32'hDEAD_0000;
    typedef enum logic [1:0] {IDLE, PROG, DONE} prog_state_t;
endpackage

/* spf_region_map.sv */
// Address classification for region boundaries and lock checks
`timescale 1ns/1ps
module spf_region_map #(
    parameter int ADDR_W = spf_pkg::ADDR_W
) (
    // Configuration
    input  wire logic [1:0]        bootSize,
    input  wire logic [3:0]        lockBits,
    // Addresses
    input  wire logic [ADDR_W-1:0] execAddr,
    input  wire logic [ADDR_W-1:0] targetAddr,
    // Results
    output logic [ADDR_W-1:0]      bootStart,
    output logic                   execInBoot,
    output logic                   targetInBoot,
    output logic                   targetInFetch,
    output logic                   writeAllowed
);
    always_comb begin
        // Every boot start is above the halt-on boundary
        case (bootSize)
            2'h0:    bootStart = spf_pkg::BOOT_START_0;
            2'h1:    bootStart = spf_pkg::BOOT_START_1;
            2'h2:    bootStart = spf_pkg::BOOT_START_2;
            default: bootStart = spf_pkg::BOOT_START_3;
        endcase
        execInBoot    = execAddr >= bootStart;
        targetInBoot  = targetAddr >= bootStart;
        targetInFetch = targetAddr < spf_pkg::HALT_REGION_START;
        // Lock bit at pos+0 clear means writes are forbidden to that region
        if (targetInBoot) begin
            writeAllowed = lockBits[spf_pkg::LK_BOOT_POS];
        end else begin
            writeAllowed = lockBits[spf_pkg::LK_APP_POS];
        end
    end
endmodule

/* self_program_flash_control.sv */
// Top of the self-programming flash controller with Avalon-MM register slave
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module self_program_flash_control #(
    parameter int          ADDR_W      = spf_pkg::ADDR_W,
    parameter logic [15:0] PROG_CYCLES = spf_pkg::PROG_CYCLES
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Avalon-MM slave
    input  wire logic [3:0]        address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    output logic [31:0]            readdata,
    output logic                   waitrequest,
    // Core side
    input  wire logic [ADDR_W-1:0] execAddr,
    input  wire logic [ADDR_W-1:0] fetchAddr,
    input  wire logic [1:0]        bootSize,
    input  wire logic              resetVecFuse_b,
    input  wire logic              chipErase,
    input  wire logic              extLockWrite,
    input  wire logic [3:0]        extLockData,
    output logic                   coreStall,
    output logic                   fetchValid,
    output logic [ADDR_W-1:0]      resetVector,
    // Flash array side
    output logic                   flashErase,
    output logic                   flashWrite,
    output logic [ADDR_W-1:0]      flashPageAddr,
    input  wire logic              flashDone
);
    typedef struct packed {
        spf_pkg::prog_state_t st;
        logic [ADDR_W-1:0]    target;
        logic                 isErase;
        logic                 haltMode;
        logic                 busy;
        logic                 refused;
        logic [3:0]           locks;
        logic [15:0]          cnt;
        logic [31:0]          rdata;
        logic                 ack;
        logic                 wreq;
        logic                 stall;
        logic                 fValid;
        logic [ADDR_W-1:0]    rvec;
        logic                 fErase;
        logic                 fWrite;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic   rstMeta_r;
    logic   rstSync_r;

    // Reset release synchroniser
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    logic [ADDR_W-1:0] bootStart;
    logic              execInBoot;
    logic              targetInBoot;
    logic              targetInFetch;
    logic              writeAllowed;
    logic [ADDR_W-1:0] cmdAddr;
    logic [ADDR_W-1:0] pageMask;

    assign pageMask = ~(ADDR_W'((1 << spf_pkg::PAGE_W) - 1));
    // Page alignment: low bits ignored, whole page erased or written
    assign cmdAddr = writedata[ADDR_W-1:0] & pageMask;

    spf_region_map #(
        .ADDR_W(ADDR_W)
    ) u_map (
        .bootSize     (bootSize),
        .lockBits     (s_r.locks),
        .execAddr     (execAddr),
        .targetAddr   (s_r.st == spf_pkg::IDLE ? cmdAddr : s_r.target),
        .bootStart    (bootStart),
        .execInBoot   (execInBoot),
        .targetInBoot (targetInBoot),
        .targetInFetch(targetInFetch),
        .writeAllowed (writeAllowed)
    );

    logic wrAcc;
    logic rdAcc;
    logic [31:0] byteAddr;
    logic fetchInFetch;

    assign wrAcc = write && !s_r.ack;
    assign rdAcc = read && !write && !s_r.ack;
    assign byteAddr = {28'h0000000, address};
    assign fetchInFetch = fetchAddr < spf_pkg::HALT_REGION_START;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.fErase = 1'b0;
        s_nxt.fWrite = 1'b0;
        s_nxt.rvec = resetVecFuse_b ? spf_pkg::RESET_APP_VEC : bootStart;

        // External programming may clear lock bits only through chip erase
        if (chipErase) begin
            s_nxt.locks = spf_pkg::LOCK_RESET;
        end else if (extLockWrite) begin
            s_nxt.locks = s_r.locks & extLockData;
        end

        case (s_r.st)
            spf_pkg::IDLE: begin
                if (wrAcc && byteAddr == spf_pkg::OFS_CMD) begin
                    s_nxt.refused = 1'b0;
                    if (!execInBoot) begin
                        s_nxt.refused = 1'b1;
                    end else if (writedata[spf_pkg::CMD_LOCKPROG]) begin
                        // Software only programs bits, never erases them
                        // Built on the next value so a same-cycle external program is kept
                        s_nxt.locks = s_nxt.locks & writedata[11:8];
                    end else if (writedata[spf_pkg::CMD_RWWCLR]) begin
                        s_nxt.busy = 1'b0;
                    end else if (writedata[spf_pkg::CMD_ERASE] ||
                                 writedata[spf_pkg::CMD_WRITE]) begin
                        // Whole-flash target range, boot pages included
                        if (!writeAllowed) begin
                            s_nxt.refused = 1'b1;
                        end else begin
                            s_nxt.st = spf_pkg::PROG;
                            s_nxt.target = cmdAddr;
                            s_nxt.isErase = writedata[spf_pkg::CMD_ERASE];
                            s_nxt.haltMode = !targetInFetch;
                            s_nxt.busy = 1'b1;
                            s_nxt.cnt = PROG_CYCLES;
                            s_nxt.fErase = writedata[spf_pkg::CMD_ERASE];
                            s_nxt.fWrite = !writedata[spf_pkg::CMD_ERASE];
                        end
                    end
                end
            end
            spf_pkg::PROG: begin
                if (s_r.cnt != 16'h0000) begin
                    s_nxt.cnt = s_r.cnt - 16'h0001;
                end
                // Either array done or timeout fallback ends the operation
                if (flashDone || s_r.cnt == 16'h0000) begin
                    s_nxt.st = spf_pkg::DONE;
                end
            end
            spf_pkg::DONE: begin
                // Busy remains set until software clears it
                s_nxt.st = spf_pkg::IDLE;
                s_nxt.haltMode = 1'b0;
            end
            default: s_nxt.st = spf_pkg::IDLE;
        endcase

        // Halt-on target stalls core for the whole operation
        s_nxt.stall = (s_nxt.st == spf_pkg::PROG) && s_nxt.haltMode;
        // Fetch-while region blocked whenever busy; halt-on region served unless stalled
        if (fetchInFetch) begin
            s_nxt.fValid = !(s_nxt.busy || s_nxt.st == spf_pkg::PROG);
        end else begin
            s_nxt.fValid = !s_nxt.stall;
        end

        if ((wrAcc || rdAcc)) begin
            s_nxt.ack = 1'b1;
        end
        // Registered copy so the bus answer leaves straight from a flip-flop
        s_nxt.wreq = !s_nxt.ack;
        if (rdAcc) begin
            case (byteAddr)
                spf_pkg::OFS_CTRL:   s_nxt.rdata = {14'h0000, bootSize, 16'h0000};
                spf_pkg::OFS_STATUS: s_nxt.rdata = {29'h00000000, s_r.refused,
                                        s_r.st != spf_pkg::IDLE, s_r.busy};
                spf_pkg::OFS_LOCKS:  s_nxt.rdata = {28'h0000000, s_r.locks};
                spf_pkg::OFS_CMD:    s_nxt.rdata = {15'h0000, s_r.target};
                default:             s_nxt.rdata = spf_pkg::BAD_ADDR_DATA;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            s_r <= '{st: spf_pkg::IDLE, locks: spf_pkg::LOCK_RESET, wreq: 1'b1,
                     rvec: spf_pkg::RESET_APP_VEC, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign readdata      = s_r.rdata;
    assign waitrequest   = s_r.wreq;
    assign coreStall     = s_r.stall;
    assign fetchValid    = s_r.fValid;
    assign resetVector   = s_r.rvec;
    assign flashErase    = s_r.fErase;
    assign flashWrite    = s_r.fWrite;
    assign flashPageAddr = s_r.target;
endmodule

/* spf_properties.sv */
// Port-level assertions for the self-programming flash controller
`timescale 1ns/1ps
module spf_properties #(
    parameter int          ADDR_W      = spf_pkg::ADDR_W,
    parameter logic [15:0] PROG_CYCLES = spf_pkg::PROG_CYCLES
) (
    // Clock, reset and bus handshake
    input wire logic              clk, rst_b, read, write, waitrequest,
    // Core and flash array side
    input wire logic              resetVecFuse_b, coreStall, fetchValid, flashErase, flashWrite,
    input wire logic [1:0]        bootSize,
    input wire logic [ADDR_W-1:0] execAddr, fetchAddr, resetVector, flashPageAddr
);
    logic [ADDR_W-1:0] bootStart;
    logic [1:0]        upCnt_r;
    logic              pulse, inHalt;
    assign bootStart = bootSize[1] ? (bootSize[0] ? spf_pkg::BOOT_START_3 : spf_pkg::BOOT_START_2)
        : (bootSize[0] ? spf_pkg::BOOT_START_1 : spf_pkg::BOOT_START_0);
    assign pulse = flashErase || flashWrite;
    assign inHalt = flashPageAddr >= spf_pkg::HALT_REGION_START;
    // The design's own reset copy lags rst_b, so bus checks wait three edges
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            upCnt_r <= 2'h0;
        else
            upCnt_r <= (upCnt_r == 2'h3) ? upCnt_r : upCnt_r + 2'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_haltProg; pulse && inHalt; endsequence
    sequence s_fetchProg; pulse && !inHalt; endsequence
    property p_answer; (read || write) && waitrequest && &upCnt_r |=> !waitrequest ##1 waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");
    property p_bootOnly; pulse |-> execAddr >= bootStart; endproperty
    a_bootOnly: assert property (p_bootOnly) else $error("store outside boot");
    property p_stall; s_haltProg |-> coreStall ##1 coreStall [*2]; endproperty
    a_stall: assert property (p_stall) else $error("core not stalled");
    property p_noStall; s_fetchProg |-> !coreStall; endproperty
    a_noStall: assert property (p_noStall) else $error("core stalled");
    property p_blocked; s_fetchProg ##1 fetchAddr < spf_pkg::HALT_REGION_START |=> !fetchValid;
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked fetch valid");
    property p_served; s_fetchProg ##1 fetchAddr >= spf_pkg::HALT_REGION_START |=> fetchValid;
    endproperty
    a_served: assert property (p_served) else $error("halt fetch not served");
    property p_page; pulse |-> flashPageAddr[spf_pkg::PAGE_W-1:0] == '0 ##1 !pulse; endproperty
    a_page: assert property (p_page) else $error("bad page pulse");
    property p_vector; &upCnt_r && resetVecFuse_b && $stable(resetVecFuse_b) |=> resetVector == '0;
    endproperty
    a_vector: assert property (p_vector) else $error("bad reset vector");
endmodule
bind self_program_flash_control spf_properties #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) chk (
    .clk(clk), .rst_b(rst_b), .read(read), .write(write), .waitrequest(waitrequest),
    .resetVecFuse_b(resetVecFuse_b), .coreStall(coreStall), .fetchValid(fetchValid),
    .flashErase(flashErase), .flashWrite(flashWrite), .bootSize(bootSize), .execAddr(execAddr),
    .fetchAddr(fetchAddr), .resetVector(resetVector), .flashPageAddr(flashPageAddr));

/* flash_array_model.sv */
// Flash array model: answers each erase or write pulse after a set delay
`timescale 1ns/1ps
module flash_array_model (
    // Pulses in, completion out
    input  wire logic       clk,
    input  wire logic       flashErase,
    input  wire logic       flashWrite,
    input  wire logic [3:0] delay,
    output logic            flashDone
);
    logic [3:0] cnt_r = 4'h0;
    initial flashDone = 1'b0;
    // A whole page per pulse; delay stays under the controller's fallback count
    always @(posedge clk) begin
        flashDone <= (cnt_r == 4'h1);
        if (flashErase || flashWrite)
            cnt_r <= delay;
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
    end
endmodule

/* self_program_flash_control_tb.sv */
// Self-checking bench for the self-programming flash controller
`timescale 1ns/1ps
module self_program_flash_control_tb;
    logic        clk = 0, rst_b = 0, read = 0, write = 0, fuse_b = 1, chipErase = 0;
    logic        extLockWrite = 0, flashDone, waitrequest, coreStall, fetchValid, fErase, fWrite;
    logic [1:0]  bootSize = 2'h0;
    logic [3:0]  address = 4'h0, extLockData = 4'hF, delay = 4'h3;
    logic [31:0] writedata = 32'h0, readdata, expQ[$], maskQ[$];
    logic [16:0] execAddr = 17'h0, fetchAddr = 17'h0, resetVector, pageAddr, page, pageQ[$];
    logic [16:0] starts[4] = '{spf_pkg::BOOT_START_0, spf_pkg::BOOT_START_1,
                               spf_pkg::BOOT_START_2, spf_pkg::BOOT_START_3};
    int          miscompares = 0, tests_run = 0, seed = 43;
    self_program_flash_control #(.PROG_CYCLES(16'h0010)) dut (.clk(clk), .rst_b(rst_b),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .execAddr(execAddr),
        .fetchAddr(fetchAddr), .bootSize(bootSize), .resetVecFuse_b(fuse_b),
        .chipErase(chipErase), .extLockWrite(extLockWrite), .extLockData(extLockData),
        .coreStall(coreStall), .fetchValid(fetchValid), .resetVector(resetVector),
        .flashErase(fErase), .flashWrite(fWrite), .flashPageAddr(pageAddr), .flashDone(flashDone));
    flash_array_model far (.clk(clk), .flashErase(fErase), .flashWrite(fWrite), .delay(delay),
        .flashDone(flashDone));
    initial forever #2 clk = ~clk;
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic waitFor(input bit done);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((done ? flashDone : !waitrequest) !== 1'b1 && n < 100);
        if ((done ? flashDone : !waitrequest) !== 1'b1) begin
            miscompares++;
            give_verdict();
        end
    endtask
    // Reads note their expectation before the request goes out
    task automatic bus(input logic [3:0] a, logic [31:0] d, bit rd = 0, logic [31:0] m = 0, e = 0);
        if (rd) begin
            maskQ.push_back(m);
            expQ.push_back(e);
        end
        address <= a;
        writedata <= d;
        read <= rd;
        write <= !rd;
        waitFor(1'b0);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic store(input logic [31:0] cmd, logic [16:0] pg, bit go);
        if (go)
            pageQ.push_back(pg);
        bus(4'hC, cmd | 32'(pg));
        if (go)
            waitFor(1'b1);
        repeat (2) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (read && waitrequest === 1'b0)
            check("readdata", readdata & maskQ.pop_front(), expQ.pop_front());
        if (fErase || fWrite)
            check("flashPageAddr", 32'(pageAddr), 32'(pageQ.pop_front()));
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        bus(4'h8, 0, 1, 32'hF, 32'(spf_pkg::LOCK_RESET));
        bus(4'h4, 0, 1, 32'h7, 32'h0);
        bus(4'h5, 0, 1, 32'hFFFF_FFFF, spf_pkg::BAD_ADDR_DATA);
        for (int s = 3; s >= 0; s--) begin
            bootSize <= 2'(s);
            fuse_b <= s[0];
            execAddr <= starts[s];
            repeat (4) @(posedge clk);
            check("resetVector", 32'(resetVector), s[0] ? 32'h0 : 32'(starts[s]));
            bus(4'h0, 0, 1, 32'h3_0000, 32'(s) << 16);
            store(32'h1, starts[s], 1);
        end
        $display("Boot sizes done");
        execAddr <= 17'h0;
        store(32'h1, 17'h00100, 0);
        bus(4'h4, 0, 1, 32'h4, 32'h4);
        execAddr <= starts[0];
        // Start from a clear flag so the set by each command is really seen
        bus(4'hC, 32'h4);
        bus(4'h4, 0, 1, 32'h7, 32'h0);
        for (int i = 0; i < 2; i++) begin
            page = 17'($random(seed)) & 17'h0FF80;
            delay <= i ? 4'h9 : 4'hC;
            fetchAddr <= i ? 17'h1C100 : 17'h00200;
            pageQ.push_back(page);
            bus(4'hC, 32'h2 | 32'(page));
            bus(4'h4, 0, 1, 32'h3, 32'h3);
            waitFor(1'b1);
            repeat (3) @(posedge clk);
            bus(4'h4, 0, 1, 32'h3, 32'h1);
            bus(4'hC, 32'h4);
            bus(4'h4, 0, 1, 32'h1, 32'h0);
        end
        $display("Busy flag done");
        bus(4'hC, 32'h0000_0E08);
        bus(4'h8, 0, 1, 32'hF, 32'hE);
        store(32'h1, 17'h00400, 0);
        bus(4'h4, 0, 1, 32'h4, 32'h4);
        store(32'h1, 17'h1F080, 1);
        extLockData <= 4'hB;
        extLockWrite <= 1'b1;
        @(posedge clk);
        extLockWrite <= 1'b0;
        bus(4'h8, 0, 1, 32'hF, 32'hA);
        store(32'h1, 17'h1F080, 0);
        bus(4'h4, 0, 1, 32'h4, 32'h4);
        chipErase <= 1'b1;
        @(posedge clk);
        chipErase <= 1'b0;
        bus(4'h8, 0, 1, 32'hF, 32'hF);
        check("pending", 32'(pageQ.size() + expQ.size()), 32'h0);
        $display("Locks done");
        give_verdict();
    end
endmodule
